/* File: verilog/ewdto_cfg.svh */
`ifndef EWDTO_CFG_SVH
`define EWDTO_CFG_SVH

// address and data widths of the bus side
`define EWDTO_AW 32
`define EWDTO_DW 64

// depths of the core write queue and the committed write record
`define EWDTO_WQ_DEPTH 4
`define EWDTO_CQ_DEPTH 4

// width of the read issue, read done and write sequence counters
`define EWDTO_CW 4

`endif

/* File: verilog/ewdto_pkg.sv */
`default_nettype none

package ewdto_pkg;

    // address tenure sequencer
    typedef enum logic [1:0] {
        A_IDLE = 2'h0,
        A_REQ  = 2'h1,
        A_WAIT = 2'h3
    } ewdto_astate_e;

    // data tenure sequencer
    typedef enum logic [1:0] {
        D_IDLE = 2'h0,
        D_WR   = 2'h1,
        D_RD   = 2'h2
    } ewdto_dstate_e;

endpackage

`default_nettype wire

/* File: verilog/ewdto_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface ewdto_fifo_if #(
    parameter int W = 8
);
    logic         push;
    logic [W-1:0] push_data;
    logic         pop;
    logic [W-1:0] head;
    logic         empty;
    logic         full;

    modport owner (output push, output push_data, output pop,
                   input head, input empty, input full);
    modport store (input push, input push_data, input pop,
                   output head, output empty, output full);
endinterface

`default_nettype wire

/* File: verilog/ewdto_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ewdto_cfg.svh"

module ewdto_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = `EWDTO_WQ_DEPTH
) (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst,
    // queue port
    ewdto_fifo_if.store q
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0]   cnt_q;
    logic [PW:0]   cnt_d;
    logic          do_push;
    logic          do_pop;

    // push is ignored while full, pop while empty
    assign do_push = q.push & ~q.full;
    assign do_pop  = q.pop & ~q.empty;
    assign q.head  = mem[rd_ptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (do_push & ~do_pop) begin
            cnt_d = cnt_q + 1'h1;
        end else if (do_pop & ~do_push) begin
            cnt_d = cnt_q - 1'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= q.push_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            q.empty  <= 1'h1;
            q.full   <= 1'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PW'(do_push);
            rd_ptr_q <= rd_ptr_q + PW'(do_pop);
            cnt_q    <= cnt_d;
            q.empty  <= (cnt_d == '0);
            q.full   <= (cnt_d == (PW+1)'(DEPTH));
        end
    end

    chk_fifo_flags: assert property (@(posedge mclk) disable iff (rst)
        (q.full == (cnt_q == (PW+1)'(DEPTH))) && (q.empty == (cnt_q == '0)))
        else $error("queue flags disagree with the fill count");

endmodule

`default_nettype wire

/* File: verilog/ewdto_core.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ewdto_cfg.svh"

module ewdto_core #(
    parameter int AW   = `EWDTO_AW,
    parameter int DW   = `EWDTO_DW,
    parameter int WQ_D = `EWDTO_WQ_DEPTH,
    parameter int CQ_D = `EWDTO_CQ_DEPTH,
    parameter int CW   = `EWDTO_CW
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // core read requests
    input  wire logic          rd_req,
    input  wire logic [AW-1:0] rd_addr,
    output logic               rd_busy,
    output logic               rd_valid,
    output logic [DW-1:0]      rd_data,
    // core write requests
    input  wire logic          wr_req,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    output logic               wr_full,
    output logic               wr_done,
    // snoop push-out
    input  wire logic          snp_req,
    input  wire logic [AW-1:0] snp_addr,
    input  wire logic [DW-1:0] snp_data,
    output logic               snp_busy,
    // address bus
    input  wire logic          address_bus_grant,
    input  wire logic          addr_ack,
    input  wire logic          addr_retry,
    output logic               abus_req,
    output logic               abus_start,
    output logic               abus_wr,
    output logic [AW-1:0]      abus_addr,
    // data bus
    input  wire logic          data_bus_grant,
    input  wire logic          write_first_strobe,
    input  wire logic          data_ack,
    input  wire logic          data_bus_busy_i,
    output logic               data_bus_busy_o,
    output logic               data_bus_busy_oe,
    input  wire logic [DW-1:0] dbus_i,
    output logic [DW-1:0]      dbus_o,
    output logic               dbus_oe
);
    import ewdto_pkg::*;

    localparam int WE = AW + DW;
    localparam int CE = 2 * CW + DW;

    ewdto_fifo_if #(.W(WE)) wq ();
    ewdto_fifo_if #(.W(CE)) cq ();

    ewdto_fifo #(.W(WE), .DEPTH(WQ_D)) u_wq (
        .mclk (mclk),
        .rst  (rst),
        .q    (wq.store)
    );

    ewdto_fifo #(.W(CE), .DEPTH(CQ_D)) u_cq (
        .mclk (mclk),
        .rst  (rst),
        .q    (cq.store)
    );

    ewdto_astate_e a_state_q;
    ewdto_dstate_e d_state_q;
    logic          abus_req_q;
    logic          abus_start_q;
    logic          abus_wr_q;
    logic [AW-1:0] abus_addr_q;
    logic          hold_valid_q;
    logic [DW-1:0] hold_data_q;
    logic          rd_want_q;
    logic [AW-1:0] rd_addr_q;
    logic          snp_valid_q;
    logic [AW-1:0] snp_addr_q;
    logic [DW-1:0] snp_data_q;
    logic [CW-1:0] rd_iss_q;
    logic [CW-1:0] rd_done_q;
    logic [CW-1:0] wseq_in_q;
    logic [CW-1:0] wseq_out_q;
    logic          rd_valid_q;
    logic [DW-1:0] rd_data_q;
    logic          wr_done_q;
    logic          busy_q;
    logic          dbus_oe_q;
    logic [DW-1:0] dbus_o_q;

    logic [CW-1:0] rd_pend_cnt;
    logic          rd_room;
    logic          any_src;
    logic          a_grant;
    logic          sel_snp;
    logic          sel_rd;
    logic          sel_wq;
    logic          a_done;
    logic [CW-1:0] cq_seq;
    logic [CW-1:0] cq_tag;
    logic [DW-1:0] cq_data;
    logic          rd_pend;
    logic          w_inorder;
    logic          qgnt;
    logic          take_wr;
    logic          take_rd;

    // address side selection, made at the address grant itself
    assign rd_pend_cnt = rd_iss_q - rd_done_q;
    assign rd_room     = ~rd_pend_cnt[CW-1];
    assign any_src     = hold_valid_q | (rd_want_q & rd_room)
                       | (~cq.full & (snp_valid_q | ~wq.empty));
    assign a_grant     = (a_state_q == A_REQ) & address_bus_grant;
    assign sel_snp     = a_grant & ~hold_valid_q & ~cq.full & snp_valid_q;
    assign sel_rd      = a_grant & ~hold_valid_q & ~sel_snp & rd_want_q & rd_room;
    assign sel_wq      = a_grant & ~hold_valid_q & ~sel_snp & ~sel_rd
                       & ~cq.full & ~wq.empty;
    assign a_done      = (a_state_q == A_WAIT) & addr_ack & ~addr_retry;

    assign wq.push      = wr_req;
    assign wq.push_data = {wr_addr, wr_data};
    assign wq.pop       = sel_wq;
    // write enters the record with the count of reads addressed before it
    assign cq.push      = a_done & abus_wr_q;
    assign cq.push_data = {wseq_in_q, rd_iss_q, hold_data_q};

    // data side choice from the ordered record
    assign {cq_seq, cq_tag, cq_data} = cq.head;
    assign rd_pend   = (rd_iss_q != rd_done_q);
    assign w_inorder = ~cq.empty & (cq_tag == rd_done_q);
    assign qgnt      = (d_state_q == D_IDLE) & data_bus_grant & ~data_bus_busy_i;
    assign take_wr   = qgnt & ~cq.empty & (write_first_strobe | w_inorder);
    assign take_rd   = qgnt & ~take_wr & rd_pend;
    assign cq.pop    = (d_state_q == D_WR) & data_ack;

    // address tenure sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_state_q    <= A_IDLE;
            abus_req_q   <= 1'h0;
            abus_start_q <= 1'h0;
        end else begin
            abus_start_q <= 1'h0;
            case (a_state_q)
                A_IDLE: begin
                    if (any_src) begin
                        abus_req_q <= 1'h1;
                        a_state_q  <= A_REQ;
                    end
                end
                A_REQ: begin
                    if (address_bus_grant) begin
                        abus_req_q   <= 1'h0;
                        abus_start_q <= 1'h1;
                        a_state_q    <= A_WAIT;
                    end
                end
                A_WAIT: begin
                    if (addr_ack) begin
                        a_state_q <= A_IDLE;
                    end
                end
                default: a_state_q <= A_IDLE;
            endcase
        end
    end

    // tenure under address; kept through a retry and reissued first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_valid_q <= 1'h0;
            abus_wr_q    <= 1'h0;
            abus_addr_q  <= '0;
            hold_data_q  <= '0;
        end else if (sel_snp) begin
            hold_valid_q <= 1'h1;
            abus_wr_q    <= 1'h1;
            abus_addr_q  <= snp_addr_q;
            hold_data_q  <= snp_data_q;
        end else if (sel_rd) begin
            hold_valid_q <= 1'h1;
            abus_wr_q    <= 1'h0;
            abus_addr_q  <= rd_addr_q;
        end else if (sel_wq) begin
            hold_valid_q <= 1'h1;
            abus_wr_q    <= 1'h1;
            {abus_addr_q, hold_data_q} <= wq.head;
        end else if (a_done) begin
            hold_valid_q <= 1'h0;
        end
    end

    // pending read and snoop slots; a new request wins over the take
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_want_q   <= 1'h0;
            rd_addr_q   <= '0;
            snp_valid_q <= 1'h0;
            snp_addr_q  <= '0;
            snp_data_q  <= '0;
        end else begin
            if (rd_req & (~rd_want_q | sel_rd)) begin
                rd_want_q <= 1'h1;
                rd_addr_q <= rd_addr;
            end else if (sel_rd) begin
                rd_want_q <= 1'h0;
            end
            if (snp_req & (~snp_valid_q | sel_snp)) begin
                snp_valid_q <= 1'h1;
                snp_addr_q  <= snp_addr;
                snp_data_q  <= snp_data;
            end else if (sel_snp) begin
                snp_valid_q <= 1'h0;
            end
        end
    end

    // issue and completion counters
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_iss_q   <= '0;
            rd_done_q  <= '0;
            wseq_in_q  <= '0;
            wseq_out_q <= '0;
        end else begin
            rd_iss_q   <= rd_iss_q + CW'(a_done & ~abus_wr_q);
            wseq_in_q  <= wseq_in_q + CW'(cq.push);
            rd_done_q  <= rd_done_q + CW'((d_state_q == D_RD) & data_ack);
            wseq_out_q <= wseq_out_q + CW'(cq.pop);
        end
    end

    // data tenure sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            d_state_q  <= D_IDLE;
            busy_q     <= 1'h0;
            dbus_oe_q  <= 1'h0;
            dbus_o_q   <= '0;
            rd_valid_q <= 1'h0;
            rd_data_q  <= '0;
            wr_done_q  <= 1'h0;
        end else begin
            rd_valid_q <= 1'h0;
            wr_done_q  <= 1'h0;
            case (d_state_q)
                D_IDLE: begin
                    if (take_wr) begin
                        d_state_q <= D_WR;
                        busy_q    <= 1'h1;
                        dbus_oe_q <= 1'h1;
                        dbus_o_q  <= cq_data;
                    end else if (take_rd) begin
                        d_state_q <= D_RD;
                        busy_q    <= 1'h1;
                    end
                end
                D_WR: begin
                    if (data_ack) begin
                        d_state_q <= D_IDLE;
                        busy_q    <= 1'h0;
                        dbus_oe_q <= 1'h0;
                        wr_done_q <= 1'h1;
                    end
                end
                D_RD: begin
                    if (data_ack) begin
                        d_state_q  <= D_IDLE;
                        busy_q     <= 1'h0;
                        rd_data_q  <= dbus_i;
                        rd_valid_q <= 1'h1;
                    end
                end
                default: d_state_q <= D_IDLE;
            endcase
        end
    end

    assign rd_busy          = rd_want_q;
    assign rd_valid         = rd_valid_q;
    assign rd_data          = rd_data_q;
    assign wr_full          = wq.full;
    assign wr_done          = wr_done_q;
    assign snp_busy         = snp_valid_q;
    assign abus_req         = abus_req_q;
    assign abus_start       = abus_start_q;
    assign abus_wr          = abus_wr_q;
    assign abus_addr        = abus_addr_q;
    assign data_bus_busy_o  = busy_q;
    assign data_bus_busy_oe = busy_q;
    assign dbus_o           = dbus_o_q;
    assign dbus_oe          = dbus_oe_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_strobe_takes_wr: assert property (
        qgnt && write_first_strobe && !cq.empty |=> d_state_q == D_WR)
        else $error("strobe with pending write did not start a write");
    chk_write_seq: assert property (
        d_state_q == D_WR && data_ack |-> cq_seq == wseq_out_q)
        else $error("write left out of queued order");
    chk_reorder_scope: assert property (
        $rose(d_state_q == D_WR) && !$past(w_inorder) |-> $past(write_first_strobe))
        else $error("write passed a read without the strobe");
    chk_in_order: assert property (
        qgnt && !write_first_strobe && rd_pend && !w_inorder |=> d_state_q == D_RD)
        else $error("read not run in address order");
    chk_envelope_prereq: assert property (
        $rose(d_state_q == D_WR) && !$past(w_inorder) |-> rd_iss_q != rd_done_q)
        else $error("envelope without a completed read address");
    chk_busy_drive: assert property (
        d_state_q == D_WR |-> data_bus_busy_o && data_bus_busy_oe && dbus_oe)
        else $error("write tenure without busy or data drive");
    chk_busy_release: assert property (
        d_state_q == D_WR && data_ack |=> !data_bus_busy_oe && !dbus_oe && wr_done)
        else $error("busy not released at write end");
    chk_read_latch: assert property (
        d_state_q == D_RD && data_ack |=> rd_valid && rd_data == $past(dbus_i))
        else $error("read data not latched at tenure end");
    chk_others_busy: assert property (
        d_state_q == D_IDLE && data_bus_busy_i |=> d_state_q == D_IDLE)
        else $error("tenure started while another master held the bus");
    chk_strobe_no_read: assert property (
        qgnt && write_first_strobe && !rd_pend && !cq.empty
        |=> d_state_q == D_WR && dbus_o == $past(cq_data))
        else $error("strobe without pending read changed write order");
    chk_fixed_at_grant: assert property (
        a_state_q == A_WAIT && $past(a_state_q) == A_WAIT
        |-> $stable(hold_data_q) && $stable(abus_addr_q))
        else $error("write content changed after address grant");
    chk_snoop_first: assert property (
        a_grant && !hold_valid_q && snp_valid_q && !cq.full
        |=> abus_start && abus_wr && abus_addr == $past(snp_addr_q))
        else $error("snoop push-out not given first place");

    cov_envelope: cover property (take_wr && !w_inorder);
    cov_read_after: cover property (take_wr && !w_inorder ##[1:40] take_rd);
    cov_two_envelopes: cover property (
        take_wr && !w_inorder ##[1:40] take_wr && !w_inorder);
    cov_addr_retry: cover property (a_state_q == A_WAIT && addr_ack && addr_retry);

endmodule

`default_nettype wire

/* File: tb/ewdto_arb_model.sv */
`timescale 1ns/100ps
`default_nettype none

module ewdto_arb_model #(
    parameter int DW = 64
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // address bus
    input  wire logic          abus_req,
    input  wire logic          abus_start,
    input  wire logic          hold_abus,
    input  wire logic          retry_first,
    output logic               address_bus_grant,
    output logic               addr_ack,
    output logic               addr_retry,
    // data bus control from the bench
    input  wire logic          gnt_cmd,
    input  wire logic          strobe_cmd,
    input  wire logic          other_busy,
    input  wire logic [3:0]    ack_dly,
    input  wire logic [DW-1:0] rd_word,
    // data bus
    input  wire logic          data_bus_busy_o,
    input  wire logic          data_bus_busy_oe,
    output logic               data_bus_grant,
    output logic               write_first_strobe,
    output logic               data_bus_busy_i,
    output logic               data_ack,
    output logic [DW-1:0]      dbus_i
);
    logic [3:0] cnt_q;
    logic       retried_q;

    assign data_bus_grant     = gnt_cmd;
    assign write_first_strobe = strobe_cmd;
    assign data_bus_busy_i    = other_busy | (data_bus_busy_o & data_bus_busy_oe);

    // address grant follows the request unless hold_abus is set, acknowledge one cycle after start;
    // with retry_first set, the first tenure is retried once
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            address_bus_grant <= 1'b0;
            addr_ack          <= 1'b0;
            addr_retry        <= 1'b0;
            retried_q         <= 1'b0;
        end else begin
            address_bus_grant <= abus_req & ~hold_abus;
            addr_ack          <= abus_start;
            addr_retry        <= abus_start & retry_first & ~retried_q;
            retried_q         <= retry_first & (retried_q | abus_start);
        end
    end

    // slave ends each single-beat tenure after ack_dly cycles; released bus toggles
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q    <= 4'h0;
            data_ack <= 1'b0;
            dbus_i   <= '0;
        end else if (data_bus_busy_o && !data_ack && cnt_q == ack_dly) begin
            cnt_q    <= 4'h0;
            data_ack <= 1'b1;
            dbus_i   <= rd_word;
        end else begin
            cnt_q    <= (data_bus_busy_o && !data_ack) ? cnt_q + 4'h1 : 4'h0;
            data_ack <= 1'b0;
            dbus_i   <= ~dbus_i;
        end
    end
endmodule

`default_nettype wire

/* File: tb/enveloped_write_data_tenure_order_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module enveloped_write_data_tenure_order_tb;
    logic        mclk, rst, rd_req, rd_busy, rd_valid, wr_req, wr_full, wr_done;
    logic        snp_req, snp_busy, address_bus_grant, addr_ack, addr_retry;
    logic        abus_req, abus_start, abus_wr, data_bus_grant, write_first_strobe;
    logic        data_ack, data_bus_busy_i, data_bus_busy_o, data_bus_busy_oe, dbus_oe;
    logic        hold_abus, gnt_cmd, strobe_cmd, other_busy, retry_first;
    logic [32:0] alog[$];
    logic [3:0]  ack_dly;
    logic [31:0] rd_addr, wr_addr, snp_addr, abus_addr;
    logic [63:0] rd_data, wr_data, snp_data, dbus_i, dbus_o, rd_word;
    logic [63:0] wlog[$];
    logic [63:0] rlog[$];
    int          n_mismatch, n_compared, n_wdone;

    ewdto_core DUT (.mclk(mclk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_busy(rd_busy), .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_full(wr_full), .wr_done(wr_done),
        .snp_req(snp_req), .snp_addr(snp_addr), .snp_data(snp_data), .snp_busy(snp_busy),
        .address_bus_grant(address_bus_grant), .addr_ack(addr_ack), .addr_retry(addr_retry),
        .abus_req(abus_req), .abus_start(abus_start), .abus_wr(abus_wr),
        .abus_addr(abus_addr), .data_bus_grant(data_bus_grant),
        .write_first_strobe(write_first_strobe), .data_ack(data_ack),
        .data_bus_busy_i(data_bus_busy_i), .data_bus_busy_o(data_bus_busy_o),
        .data_bus_busy_oe(data_bus_busy_oe), .dbus_i(dbus_i), .dbus_o(dbus_o),
        .dbus_oe(dbus_oe));

    ewdto_arb_model ARB (.mclk(mclk), .rst(rst), .abus_req(abus_req),
        .abus_start(abus_start), .hold_abus(hold_abus), .retry_first(retry_first),
        .address_bus_grant(address_bus_grant), .addr_ack(addr_ack),
        .addr_retry(addr_retry), .gnt_cmd(gnt_cmd), .strobe_cmd(strobe_cmd),
        .other_busy(other_busy), .ack_dly(ack_dly), .rd_word(rd_word),
        .data_bus_busy_o(data_bus_busy_o), .data_bus_busy_oe(data_bus_busy_oe),
        .data_bus_grant(data_bus_grant), .write_first_strobe(write_first_strobe),
        .data_bus_busy_i(data_bus_busy_i), .data_ack(data_ack), .dbus_i(dbus_i));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // log of data words, address tenures and write completions
    always @(posedge mclk) begin
        if (data_ack === 1'b1 && dbus_oe === 1'b1) wlog.push_back(dbus_o);
        if (rd_valid === 1'b1) rlog.push_back(rd_data);
        if (abus_start === 1'b1) alog.push_back({abus_wr, abus_addr});
        if (wr_done === 1'b1) n_wdone++;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task complete_run;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic timeout(input string what);
        n_mismatch++;
        $display("ERROR %s expected done seen timeout", what);
        complete_run();
    endtask

    // kind 0 read, 1 write, 2 snoop push-out; starts and ends at a falling edge
    task automatic push(input int kind, input logic [31:0] a, input logic [63:0] d);
        int i;
        for (i = 0; i < 40; i++) begin
            if ((kind == 0 ? rd_busy : kind == 1 ? wr_full : snp_busy) === 1'b0) break;
            @(negedge mclk);
        end
        if (i == 40) timeout("request slot");
        case (kind)
            0: begin rd_req = 1'b1; rd_addr = a; end
            1: begin wr_req = 1'b1; wr_addr = a; wr_data = d; end
            default: begin snp_req = 1'b1; snp_addr = a; snp_data = d; end
        endcase
        @(negedge mclk);
        rd_req = 1'b0;
        wr_req = 1'b0;
        snp_req = 1'b0;
        @(negedge mclk);
    endtask

    task automatic settle;
        int i, q;
        q = 0;
        for (i = 0; i < 80 && q < 6; i++) begin
            @(negedge mclk);
            q = (abus_req || rd_busy || snp_busy) ? 0 : q + 1;
        end
        if (q < 6) timeout("address tenures");
    endtask

    task automatic grant(input logic st);
        int i;
        logic seen;
        seen = 1'b0;
        gnt_cmd = 1'b1;
        strobe_cmd = st;
        @(negedge mclk);
        gnt_cmd = 1'b0;
        strobe_cmd = 1'b0;
        for (i = 0; i < 40; i++) begin
            if (data_bus_busy_o === 1'b1) seen = 1'b1;
            else if (seen) break;
            @(negedge mclk);
        end
        if (i == 40) timeout("data tenure");
        @(negedge mclk);
    endtask

    task automatic exp_log(input logic wr, input logic [63:0] exp);
        if ((wr ? wlog.size() : rlog.size()) == 0) begin
            n_compared++;
            n_mismatch++;
            $display("ERROR %s expected %h seen none", wr ? "write" : "read", exp);
        end else
            check(wr ? "write data" : "read data", exp, wr ? wlog.pop_front() : rlog.pop_front());
    endtask

    task automatic s_in_order;
        ack_dly = 4'h0;
        rd_word = 64'h1111_0000_0000_0001;
        push(0, 32'h0000_1000, 64'h0);
        push(1, 32'h0000_2000, 64'hA000_0000_0000_0001);
        settle();
        grant(1'b0);
        exp_log(1'b0, rd_word);
        check("write before read", 64'h0, 64'(wlog.size()));
        grant(1'b0);
        exp_log(1'b1, 64'hA000_0000_0000_0001);
    endtask

    task automatic s_envelope;
        ack_dly = 4'h3;
        rd_word = 64'h2222_0000_0000_0002;
        push(0, 32'h0000_1100, 64'h0);
        push(1, 32'h0000_2100, 64'hB000_0000_0000_0002);
        push(1, 32'h0000_2200, 64'hB000_0000_0000_0003);
        settle();
        grant(1'b1);
        exp_log(1'b1, 64'hB000_0000_0000_0002);
        check("read during envelope", 64'h0, 64'(rlog.size()));
        grant(1'b1);
        exp_log(1'b1, 64'hB000_0000_0000_0003);
        grant(1'b0);
        exp_log(1'b0, rd_word);
    endtask

    task automatic s_no_read;
        ack_dly = 4'h1;
        push(1, 32'h0000_2300, 64'hC000_0000_0000_0004);
        push(1, 32'h0000_2400, 64'hC000_0000_0000_0005);
        settle();
        grant(1'b1);
        exp_log(1'b1, 64'hC000_0000_0000_0004);
        grant(1'b1);
        exp_log(1'b1, 64'hC000_0000_0000_0005);
    endtask

    task automatic s_snoop;
        ack_dly = 4'h2;
        hold_abus = 1'b1;
        alog.delete();
        push(1, 32'h0000_2500, 64'hD000_0000_0000_0006);
        push(2, 32'h0000_3000, 64'h5000_0000_0000_0007);
        hold_abus = 1'b0;
        settle();
        check("snoop address first", 64'({1'b1, 32'h0000_3000}), 64'(alog[0]));
        check("queued write address", 64'({1'b1, 32'h0000_2500}), 64'(alog[1]));
        grant(1'b0);
        exp_log(1'b1, 64'h5000_0000_0000_0007);
        grant(1'b0);
        exp_log(1'b1, 64'hD000_0000_0000_0006);
    endtask

    task automatic s_other;
        ack_dly = 4'h5;
        rd_word = 64'h3333_0000_0000_0008;
        retry_first = 1'b1;
        alog.delete();
        push(0, 32'h0000_1200, 64'h0);
        push(1, 32'h0000_2600, 64'hE000_0000_0000_0009);
        settle();
        retry_first = 1'b0;
        check("reissued read address", 64'({1'b0, 32'h0000_1200}), 64'(alog[1]));
        check("write address after read", 64'({1'b1, 32'h0000_2600}), 64'(alog[2]));
        grant(1'b1);
        exp_log(1'b1, 64'hE000_0000_0000_0009);
        other_busy = 1'b1;
        gnt_cmd = 1'b1;
        @(negedge mclk);
        gnt_cmd = 1'b0;
        repeat (6) @(negedge mclk);
        check("busy under other master", 64'h0, 64'(data_bus_busy_o));
        other_busy = 1'b0;
        @(negedge mclk);
        grant(1'b0);
        exp_log(1'b0, rd_word);
    endtask

    initial begin
        rst = 1'b1;
        rd_req = 1'b0;
        wr_req = 1'b0;
        snp_req = 1'b0;
        rd_addr = '0;
        wr_addr = '0;
        snp_addr = '0;
        wr_data = '0;
        snp_data = '0;
        hold_abus = 1'b0;
        retry_first = 1'b0;
        gnt_cmd = 1'b0;
        strobe_cmd = 1'b0;
        other_busy = 1'b0;
        ack_dly = 4'h0;
        rd_word = '0;
        n_mismatch = 0;
        n_compared = 0;
        n_wdone = 0;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        s_in_order();
        s_envelope();
        s_no_read();
        s_snoop();
        s_other();
        check("stray tenures", 64'h0, 64'(wlog.size() + rlog.size()));
        check("write done pulses", 64'h8, 64'(n_wdone));
        complete_run();
    end
endmodule

`default_nettype wire
